// *** verilog/pts_pkg.sv ***
// constants, kinds and carriers of the port ptp timestamp unit
// assumes a 32-bit apb slave with word-indexed registers
package pts_pkg;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int          IDX_W       = 14;
  localparam logic [13:0] IDX_RX_LAT  = 14'h0C00;
  localparam logic [13:0] IDX_TX_LAT  = 14'h0C02;
  localparam logic [13:0] IDX_ASYM    = 14'h0C04;
  localparam logic [13:0] IDX_REQ_HI  = 14'h0C08;
  localparam logic [13:0] IDX_REQ_LO  = 14'h0C0A;
  localparam logic [13:0] IDX_SYNC_HI = 14'h0C0C;
  localparam logic [13:0] IDX_SYNC_LO = 14'h0C0E;
  localparam logic [13:0] IDX_RESP_HI = 14'h0C10;
  localparam logic [13:0] IDX_RESP_LO = 14'h0C12;
  localparam logic [13:0] IDX_FLAGS   = 14'h0C14;
  localparam logic [13:0] IDX_IRQ_ON  = 14'h0C16;

  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [15:0] RX_LAT_RST  = 16'h019F;
  localparam logic [15:0] TX_LAT_RST  = 16'h002D;
  localparam logic [15:0] ASYM_RST    = 16'h0000;
  localparam logic [31:0] STAMP_RST   = 32'h0000_0000;
  localparam int          ASYM_SIGN   = 15;
  localparam int          REG_W       = 16;
  localparam int          STAMP_W     = 32;
  localparam int          CORR_W      = 64;
  localparam int          NUM_CH      = 3;
  localparam int          RSVD_TOP    = 12;

  // ----------------------------------------------------------------
  // ptp event kinds, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    MSG_OTHER = 5'h01,
    MSG_SYNC  = 5'h02,
    MSG_DREQ  = 5'h04,
    MSG_PREQ  = 5'h08,
    MSG_PRESP = 5'h10
  } pts_msg_e;

  // channel 0 request, 1 sync, 2 pdelay response
  localparam int          CH_BIT [3]  = '{14, 15, 13};
  localparam logic [4:0]  CH_KIND [3] = '{5'h0C, 5'h02, 5'h10};

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    pts_msg_e    kind;
    logic [63:0] corr;
  } pts_msg_s;

  typedef struct packed {
    logic        valid;
    pts_msg_e    kind;
    logic [31:0] ns;
  } pts_stamp_s;

endpackage

// *** verilog/pts_port.sv ***
// port ptp timestamp unit: latencies, asymmetry correction, egress
// stamps and their availability flags behind an apb slave
// assumes message and stamp strobes synchronous to MCLK
//
// Behaviour
// RULE_01: rx path latency register, 16 bits, resets to 415 ns.
// RULE_02: tx path latency register, 16 bits, resets to 45 ns.
// RULE_03: asymmetry top bit set means negative magnitude, clear positive.
// RULE_04: add signed asymmetry to ingress sync and pdelay_resp correction.
// RULE_05: subtract signed asymmetry from egress delay_req and pdelay_req.
// RULE_06: read-only 32-bit request egress stamp, high and low words.
// RULE_07: read-only 32-bit sync egress stamp, high and low words.
// RULE_08: read-only 32-bit pdelay_resp egress stamp, high and low words.
// RULE_09: flag bit 15 sets on a new sync stamp.
// RULE_10: flag bit 14 sets on a new request stamp.
// RULE_11: flag bit 13 sets on a new pdelay_resp stamp.
// RULE_12: flags clear by writing one; their or is ptp irq status.
// RULE_13: enable bits at flag positions, reset zero; or is irq enable.
// RULE_14: status bits 12:0 read zero; stamps hold until next frame.
// RULE_15: software reads both words before clearing the flag.
module pts_port
(
  input  wire logic                MCLK,            // clock
  input  wire logic                RST,             // sync reset
  input  wire logic                PSEL,            // apb select
  input  wire logic                PENABLE,         // apb enable
  input  wire logic                PWRITE,          // apb direction
  input  wire logic [15:0]         PADDR,           // apb address
  input  wire logic [31:0]         PWDATA,          // apb write data
  input  wire logic [3:0]          PSTRB,           // apb byte strobes
  output      logic [31:0]         PRDATA,          // apb read data
  output      logic                PREADY,          // apb ready
  output      logic                PSLVERR,         // apb error
  input  wire pts_pkg::pts_msg_s   RX_MSG,          // ingress message
  output      pts_pkg::pts_msg_s   RX_MSG_OUT,      // ingress corrected
  input  wire pts_pkg::pts_msg_s   TX_MSG,          // egress message
  output      pts_pkg::pts_msg_s   TX_MSG_OUT,      // egress corrected
  input  wire pts_pkg::pts_stamp_s TX_STAMP,        // egress stamp
  output      logic [15:0]         RX_LATENCY,      // rx path latency
  output      logic [15:0]         TX_LATENCY,      // tx path latency
  output      logic                PTP_IRQ_STATUS,  // or of flags
  output      logic                PTP_IRQ_ENABLE,  // or of enables
  output      logic                IRQ              // level interrupt
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [13:0] idx;
  logic        aligned;
  logic        sel_rx;
  logic        sel_tx;
  logic        sel_asym;
  logic        sel_req_hi;
  logic        sel_req_lo;
  logic        sel_sync_hi;
  logic        sel_sync_lo;
  logic        sel_resp_hi;
  logic        sel_resp_lo;
  logic        sel_flags;
  logic        sel_irq_on;
  logic        hit;
  logic        setup;
  logic        access;
  logic        wr;

  assign idx         = PADDR[15:2];
  assign aligned     = PADDR[1:0] == 2'h0;
  assign sel_rx      = aligned && idx == pts_pkg::IDX_RX_LAT;
  assign sel_tx      = aligned && idx == pts_pkg::IDX_TX_LAT;
  assign sel_asym    = aligned && idx == pts_pkg::IDX_ASYM;
  assign sel_req_hi  = aligned && idx == pts_pkg::IDX_REQ_HI;
  assign sel_req_lo  = aligned && idx == pts_pkg::IDX_REQ_LO;
  assign sel_sync_hi = aligned && idx == pts_pkg::IDX_SYNC_HI;
  assign sel_sync_lo = aligned && idx == pts_pkg::IDX_SYNC_LO;
  assign sel_resp_hi = aligned && idx == pts_pkg::IDX_RESP_HI;
  assign sel_resp_lo = aligned && idx == pts_pkg::IDX_RESP_LO;
  assign sel_flags   = aligned && idx == pts_pkg::IDX_FLAGS;
  assign sel_irq_on  = aligned && idx == pts_pkg::IDX_IRQ_ON;
  assign hit         = sel_rx | sel_tx | sel_asym | sel_req_hi
                     | sel_req_lo | sel_sync_hi | sel_sync_lo
                     | sel_resp_hi | sel_resp_lo | sel_flags
                     | sel_irq_on;
  assign setup       = PSEL && !PENABLE;
  assign access      = PSEL && PENABLE;
  assign wr          = access && PWRITE;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [15:0] rx_lat_q;
  logic [15:0] tx_lat_q;
  logic [15:0] asym_q;
  logic [15:0] irq_on_q;
  logic [15:0] rx_lat_d;
  logic [15:0] tx_lat_d;
  logic [15:0] asym_d;
  logic [15:0] irq_on_d;
  logic [15:0] wmask;

  assign wmask    = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
  assign rx_lat_d = (rx_lat_q & ~wmask) | (PWDATA[15:0] & wmask);
  assign tx_lat_d = (tx_lat_q & ~wmask) | (PWDATA[15:0] & wmask);
  assign asym_d   = (asym_q & ~wmask) | (PWDATA[15:0] & wmask);
  assign irq_on_d = (irq_on_q & ~wmask) | (PWDATA[15:0] & wmask);

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      rx_lat_q <= pts_pkg::RX_LAT_RST; // RULE_01
      tx_lat_q <= pts_pkg::TX_LAT_RST; // RULE_02
      asym_q   <= pts_pkg::ASYM_RST;
    end
    else if (wr)
    begin
      if (sel_rx)
        rx_lat_q <= rx_lat_d; // RULE_01
      if (sel_tx)
        tx_lat_q <= tx_lat_d; // RULE_02
      if (sel_asym)
        asym_q <= asym_d;
    end
  end

  // enable bits only at flag positions
  logic [15:0] flag_mask;
  logic [15:0] flag_vec;

  always_ff @(posedge MCLK)
  begin
    if (RST)
      irq_on_q <= '0; // RULE_13
    else if (wr && sel_irq_on)
      irq_on_q <= irq_on_d & flag_mask; // RULE_13
  end

  assign RX_LATENCY = rx_lat_q;
  assign TX_LATENCY = tx_lat_q;

  // ----------------------------------------------------------------
  // asymmetry correction
  // ----------------------------------------------------------------
  logic [63:0] asym_mag;
  logic [63:0] asym_signed;
  logic        rx_adj;
  logic        tx_adj;
  logic        rx_msg_v_q;
  logic        tx_msg_v_q;
  pts_pkg::pts_msg_e rx_kind_q;
  pts_pkg::pts_msg_e tx_kind_q;
  logic [63:0] rx_corr_q;
  logic [63:0] tx_corr_q;

  assign asym_mag    = {49'h0, asym_q[14:0]};
  assign asym_signed = asym_q[pts_pkg::ASYM_SIGN] ? // RULE_03
                       64'h0 - asym_mag : asym_mag;
  assign rx_adj      = RX_MSG.kind == pts_pkg::MSG_SYNC
                    || RX_MSG.kind == pts_pkg::MSG_PRESP;
  assign tx_adj      = TX_MSG.kind == pts_pkg::MSG_DREQ
                    || TX_MSG.kind == pts_pkg::MSG_PREQ;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      rx_msg_v_q <= 1'b0;
      tx_msg_v_q <= 1'b0;
      rx_kind_q  <= pts_pkg::MSG_OTHER;
      tx_kind_q  <= pts_pkg::MSG_OTHER;
      rx_corr_q  <= '0;
      tx_corr_q  <= '0;
    end
    else
    begin
      rx_msg_v_q <= RX_MSG.valid;
      tx_msg_v_q <= TX_MSG.valid;
      rx_kind_q  <= RX_MSG.kind;
      tx_kind_q  <= TX_MSG.kind;
      rx_corr_q  <= rx_adj ? RX_MSG.corr + asym_signed // RULE_04
                           : RX_MSG.corr;
      tx_corr_q  <= tx_adj ? TX_MSG.corr - asym_signed // RULE_05
                           : TX_MSG.corr;
    end
  end

  assign RX_MSG_OUT = '{valid: rx_msg_v_q, kind: rx_kind_q,
                        corr: rx_corr_q};
  assign TX_MSG_OUT = '{valid: tx_msg_v_q, kind: tx_kind_q,
                        corr: tx_corr_q};

  // ----------------------------------------------------------------
  // egress stamps and availability flags
  // ----------------------------------------------------------------
  logic [31:0] stamp_q [pts_pkg::NUM_CH];
  logic [2:0]  flag_q;
  logic [2:0]  cap;
  logic [2:0]  clr;

  assign flag_vec[pts_pkg::RSVD_TOP:0]  = '0; // RULE_14
  assign flag_mask[pts_pkg::RSVD_TOP:0] = '0;

  for (genvar c = 0; c < pts_pkg::NUM_CH; c++)
  begin : g_ch
    assign cap[c] = TX_STAMP.valid
                 && |(TX_STAMP.kind & pts_pkg::CH_KIND[c]);
    assign clr[c] = wr && sel_flags && wmask[pts_pkg::CH_BIT[c]]
                 && PWDATA[pts_pkg::CH_BIT[c]]; // RULE_12
    assign flag_vec[pts_pkg::CH_BIT[c]]  = flag_q[c];
    assign flag_mask[pts_pkg::CH_BIT[c]] = 1'b1;

    always_ff @(posedge MCLK)
    begin
      if (RST)
      begin
        stamp_q[c] <= pts_pkg::STAMP_RST;
        flag_q[c]  <= 1'b0;
      end
      else
      begin
        if (cap[c])
          stamp_q[c] <= TX_STAMP.ns; // RULE_06 RULE_07 RULE_08 RULE_14
        // a new stamp wins over a clear in the same cycle
        flag_q[c] <= cap[c] | flag_q[c] & ~clr[c]; // RULE_09 RULE_10 RULE_11
      end
    end
  end

  assign PTP_IRQ_STATUS = |flag_q; // RULE_12
  assign PTP_IRQ_ENABLE = |irq_on_q; // RULE_13
  assign IRQ            = |(flag_vec & irq_on_q);

  // ----------------------------------------------------------------
  // apb read path, data registered in the setup cycle
  // ----------------------------------------------------------------
  logic [15:0] rdata;
  logic [31:0] prdata_q;
  logic        slverr_q;

  always_comb
  begin
    rdata = '0;
    if (sel_rx)
      rdata = rx_lat_q;
    else if (sel_tx)
      rdata = tx_lat_q;
    else if (sel_asym)
      rdata = asym_q;
    else if (sel_req_hi)
      rdata = stamp_q[0][31:16]; // RULE_06
    else if (sel_req_lo)
      rdata = stamp_q[0][15:0]; // RULE_06
    else if (sel_sync_hi)
      rdata = stamp_q[1][31:16]; // RULE_07
    else if (sel_sync_lo)
      rdata = stamp_q[1][15:0]; // RULE_07
    else if (sel_resp_hi)
      rdata = stamp_q[2][31:16]; // RULE_08
    else if (sel_resp_lo)
      rdata = stamp_q[2][15:0]; // RULE_08
    else if (sel_flags)
      rdata = flag_vec; // RULE_14
    else if (sel_irq_on)
      rdata = irq_on_q;
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      prdata_q <= '0;
      slverr_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= (hit && !PWRITE) ? {16'h0000, rdata} : '0;
      slverr_q <= !hit;
    end
  end

  assign PRDATA  = prdata_q;
  assign PREADY  = 1'b1;
  assign PSLVERR = slverr_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_rx_wr;
    @(posedge MCLK) disable iff (RST)
    (wr && sel_rx && PSTRB[1:0] == 2'h3)
    |=> RX_LATENCY == $past(PWDATA[15:0]);
  endproperty
  a_rx_wr: assert property (p_rx_wr) // RULE_01
    else $error("rx latency write lost");

  property p_tx_keep;
    @(posedge MCLK) disable iff (RST)
    !(wr && sel_tx) |=> $stable(TX_LATENCY);
  endproperty
  a_tx_keep: assert property (p_tx_keep) // RULE_02
    else $error("tx latency changed without write");

  property p_rx_neg;
    @(posedge MCLK) disable iff (RST)
    (RX_MSG.kind == pts_pkg::MSG_SYNC && asym_q[15])
    |=> RX_MSG_OUT.corr == $past(RX_MSG.corr)
        - {49'h0, $past(asym_q[14:0])};
  endproperty
  a_rx_neg: assert property (p_rx_neg) // RULE_03
    else $error("negative asymmetry not applied");

  property p_rx_pos;
    @(posedge MCLK) disable iff (RST)
    (RX_MSG.kind == pts_pkg::MSG_PRESP && !asym_q[15])
    |=> RX_MSG_OUT.corr == $past(RX_MSG.corr)
        + {49'h0, $past(asym_q[14:0])};
  endproperty
  a_rx_pos: assert property (p_rx_pos) // RULE_04
    else $error("ingress correction wrong");

  property p_rx_pass;
    @(posedge MCLK) disable iff (RST)
    RX_MSG.kind == pts_pkg::MSG_DREQ
    |=> RX_MSG_OUT.corr == $past(RX_MSG.corr);
  endproperty
  a_rx_pass: assert property (p_rx_pass) // RULE_04
    else $error("ingress request altered");

  property p_tx_sub;
    @(posedge MCLK) disable iff (RST)
    (TX_MSG.kind == pts_pkg::MSG_PREQ && !asym_q[15])
    |=> TX_MSG_OUT.corr == $past(TX_MSG.corr)
        - {49'h0, $past(asym_q[14:0])};
  endproperty
  a_tx_sub: assert property (p_tx_sub) // RULE_05
    else $error("egress correction wrong");

  property p_req_cap;
    @(posedge MCLK) disable iff (RST)
    (TX_STAMP.valid && TX_STAMP.kind == pts_pkg::MSG_DREQ)
    |=> stamp_q[0] == $past(TX_STAMP.ns) && flag_vec[14];
  endproperty
  a_req_cap: assert property (p_req_cap) // RULE_10
    else $error("request stamp not captured");

  property p_sync_cap;
    @(posedge MCLK) disable iff (RST)
    (TX_STAMP.valid && TX_STAMP.kind == pts_pkg::MSG_SYNC)
    |=> stamp_q[1] == $past(TX_STAMP.ns) && flag_vec[15];
  endproperty
  a_sync_cap: assert property (p_sync_cap) // RULE_09
    else $error("sync stamp not captured");

  property p_resp_cap;
    @(posedge MCLK) disable iff (RST)
    (TX_STAMP.valid && TX_STAMP.kind == pts_pkg::MSG_PRESP)
    |=> stamp_q[2] == $past(TX_STAMP.ns) && flag_vec[13];
  endproperty
  a_resp_cap: assert property (p_resp_cap) // RULE_11
    else $error("response stamp not captured");

  property p_w1c;
    @(posedge MCLK) disable iff (RST)
    (wr && sel_flags && PSTRB[1] && PWDATA[15] && !cap[1])
    |=> !flag_vec[15] && PTP_IRQ_STATUS == (flag_vec[14:13] != 2'b00);
  endproperty
  a_w1c: assert property (p_w1c) // RULE_12
    else $error("sync flag not cleared");

  property p_irq;
    @(posedge MCLK) disable iff (RST)
    (wr && sel_irq_on && PSTRB[1] && PWDATA[14] && flag_vec[14])
    |=> IRQ && PTP_IRQ_ENABLE;
  endproperty
  a_irq: assert property (p_irq) // RULE_13
    else $error("enabled flag gives no interrupt");

  property p_hold;
    @(posedge MCLK) disable iff (RST)
    !cap[1] |=> $stable(stamp_q[1]);
  endproperty
  a_hold: assert property (p_hold) // RULE_14
    else $error("sync stamp moved without frame");

  property p_rsvd;
    @(posedge MCLK) disable iff (RST)
    (setup && sel_flags && !PWRITE) |=> PRDATA[12:0] == 13'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) // RULE_14
    else $error("reserved flag bits not zero");

  c_sync_read: cover property (@(posedge MCLK) disable iff (RST)
    cap[1] ##[1:50] (access && sel_sync_hi && !PWRITE));
  c_clear: cover property (@(posedge MCLK) disable iff (RST)
    flag_vec[15] ##1 clr[1] ##1 !flag_vec[15]);
  c_neg_rx: cover property (@(posedge MCLK) disable iff (RST)
    RX_MSG.valid && rx_adj && asym_q[15]);
  c_set_clr: cover property (@(posedge MCLK) disable iff (RST)
    cap[0] && clr[0]);

endmodule

// *** testbench/pts_link_model.sv ***
// link partner model: launches ingress ptp messages, keeps last egress
// assumes the same clock as the port unit, requests from the bench
module pts_link_model
(
  input  wire logic              clk,     // clock
  input  wire logic              send,    // launch one message
  input  wire pts_pkg::pts_msg_e kind,    // kind to launch
  input  wire logic [63:0]       corr,    // correction to launch
  output      pts_pkg::pts_msg_s rx_msg,  // toward the port
  input  wire pts_pkg::pts_msg_s tx_msg,  // from the port
  output      pts_pkg::pts_msg_s seen     // last egress message
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // wire side
  // ----------------------------------------------------------------
  initial
  begin
    rx_msg = '{1'b0, pts_pkg::MSG_OTHER, 64'h0000};
    seen   = '{1'b0, pts_pkg::MSG_OTHER, 64'h0000};
  end

  // idle frames carry a changing pattern, never the old value
  always @(posedge clk)
  begin
    if (send)
      rx_msg <= '{1'b1, kind, corr};
    else
      rx_msg <= '{1'b0, pts_pkg::MSG_OTHER, ~rx_msg.corr};
    if (tx_msg.valid)
      seen <= tx_msg;
  end
endmodule

// *** testbench/tb_port_ptp_timestamp_unit.sv ***
// self-checking bench for the port ptp timestamp unit
// assumes pts_pkg, pts_port and pts_link_model are compiled first
module tb_port_ptp_timestamp_unit;
  timeunit 1ns;
  timeprecision 1ps;

  logic                MCLK, RST, PSEL, PENABLE, PWRITE;
  logic [15:0]         PADDR, RX_LATENCY, TX_LATENCY;
  logic [31:0]         PWDATA, PRDATA, rd;
  logic [3:0]          PSTRB;
  logic                PREADY, PSLVERR, PTP_IRQ_STATUS, PTP_IRQ_ENABLE;
  logic                IRQ, err, send;
  pts_pkg::pts_msg_s   rx_msg, rx_out, tx_msg, tx_out, seen;
  pts_pkg::pts_stamp_s stamp;
  pts_pkg::pts_msg_e   send_kind;
  logic [63:0]         send_corr;
  int                  fails, comparisons;

  pts_port pts_port_inst (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RX_MSG(rx_msg), .RX_MSG_OUT(rx_out), .TX_MSG(tx_msg),
    .TX_MSG_OUT(tx_out), .TX_STAMP(stamp), .RX_LATENCY(RX_LATENCY),
    .TX_LATENCY(TX_LATENCY), .PTP_IRQ_STATUS(PTP_IRQ_STATUS),
    .PTP_IRQ_ENABLE(PTP_IRQ_ENABLE), .IRQ(IRQ));

  pts_link_model pts_link_model_inst (.clk(MCLK), .send(send),
    .kind(send_kind), .corr(send_corr), .rx_msg(rx_msg),
    .tx_msg(tx_out), .seen(seen));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic apb(input logic wrt, input logic [15:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge MCLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wrt;
    PADDR   <= a;
    PWDATA  <= d;
    PSTRB   <= s;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do
      @(posedge MCLK);
    while (PREADY !== 1'b1);
    rd      = PRDATA;
    err     = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  function automatic logic [15:0] ad(input logic [13:0] i);
    return {i, 2'b00};
  endfunction

  task automatic wr(input logic [13:0] i, input logic [31:0] d);
    apb(1'b1, ad(i), d, 4'hF);
    #1;
  endtask

  task automatic rdchk(input string w, input logic [13:0] i,
                       input logic [31:0] e);
    apb(1'b0, ad(i), 32'h0000_0000, 4'h0);
    chk(w, rd, e);
  endtask

  task automatic put_stamp(input pts_pkg::pts_msg_e k,
                           input logic [31:0] ns);
    @(posedge MCLK);
    stamp <= '{1'b1, k, ns};
    @(posedge MCLK);
    stamp <= '{1'b0, pts_pkg::MSG_OTHER, ~ns};
    @(posedge MCLK);
    #1;
  endtask

  task automatic one_corr(input logic tx, input pts_pkg::pts_msg_e k,
                          input logic [15:0] asym, input logic [63:0] c, e);
    wr(pts_pkg::IDX_ASYM, {16'h0000, asym});
    @(posedge MCLK);
    send      <= !tx;
    send_kind <= k;
    send_corr <= c;
    if (tx)
      tx_msg <= '{1'b1, k, c};
    @(posedge MCLK);
    send   <= 1'b0;
    tx_msg <= '{1'b0, pts_pkg::MSG_OTHER, ~c};
    @(posedge MCLK);
    #1;
    if (tx)
      chk("egress corr", seen.corr, e);
    else
    begin
      chk("ingress valid", rx_out.valid, 1'b1);
      chk("ingress corr", rx_out.corr, e);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [13:0] i;
    logic [31:0] e;
    for (int n = 0; n < 12; n++)
    begin
      i = 14'h0C00 + 14'(2 * n);
      e = (n == 0) ? 32'h0000_019F : (n == 1) ? 32'h0000_002D : 32'h0000_0000;
      rdchk("reset", i, e);
      chk("reset err", err, (n == 3) ? 1'b1 : 1'b0);
    end
  endtask

  task automatic t_latency;
    wr(pts_pkg::IDX_RX_LAT, 32'h0000_0123);
    rdchk("rx lat full", pts_pkg::IDX_RX_LAT, 32'h0000_0123);
    apb(1'b1, ad(pts_pkg::IDX_RX_LAT), 32'h0000_ABCD, 4'h1);
    rdchk("rx lat", pts_pkg::IDX_RX_LAT, 32'h0000_01CD);
    wr(pts_pkg::IDX_TX_LAT, 32'hFFFF_0064);
    rdchk("tx lat", pts_pkg::IDX_TX_LAT, 32'h0000_0064);
    chk("rx lat port", RX_LATENCY, 16'h01CD);
    chk("tx lat port", TX_LATENCY, 16'h0064);
    apb(1'b1, 16'h3002, 32'hFFFF_FFFF, 4'hF);
    chk("unaligned err", err, 1'b1);
    rdchk("rx lat kept", pts_pkg::IDX_RX_LAT, 32'h0000_01CD);
  endtask

  task automatic t_corr;
    one_corr(1'b0, pts_pkg::MSG_SYNC, 16'hFFFF, 64'h0000,
             64'hFFFF_FFFF_FFFF_8001);
    one_corr(1'b0, pts_pkg::MSG_PRESP, 16'h0007, 64'h0064,
             64'h006B);
    one_corr(1'b0, pts_pkg::MSG_DREQ, 16'h0007, 64'h0064,
             64'h0064);
    one_corr(1'b1, pts_pkg::MSG_DREQ, 16'h8005, 64'h0064,
             64'h0069);
    one_corr(1'b1, pts_pkg::MSG_PREQ, 16'h0007, 64'h0064,
             64'h005D);
    one_corr(1'b1, pts_pkg::MSG_SYNC, 16'h0007, 64'h0064,
             64'h0064);
  endtask

  task automatic t_stamps;
    put_stamp(pts_pkg::MSG_SYNC, 32'h1234_5678);
    rdchk("flags", pts_pkg::IDX_FLAGS, 32'h0000_8000);
    rdchk("sync hi", pts_pkg::IDX_SYNC_HI, 32'h0000_1234);
    rdchk("sync lo", pts_pkg::IDX_SYNC_LO, 32'h0000_5678);
    wr(pts_pkg::IDX_FLAGS, 32'h0000_8000);
    put_stamp(pts_pkg::MSG_DREQ, 32'hA1B2_C3D4);
    rdchk("flags", pts_pkg::IDX_FLAGS, 32'h0000_4000);
    put_stamp(pts_pkg::MSG_PREQ, 32'h0BAD_F00D);
    wr(pts_pkg::IDX_REQ_HI, 32'h0000_5555);
    rdchk("req hi", pts_pkg::IDX_REQ_HI, 32'h0000_0BAD);
    rdchk("req lo", pts_pkg::IDX_REQ_LO, 32'h0000_F00D);
    put_stamp(pts_pkg::MSG_PRESP, 32'hCAFE_0001);
    rdchk("flags", pts_pkg::IDX_FLAGS, 32'h0000_6000);
    rdchk("resp hi", pts_pkg::IDX_RESP_HI, 32'h0000_CAFE);
    rdchk("resp lo", pts_pkg::IDX_RESP_LO, 32'h0000_0001);
    put_stamp(pts_pkg::MSG_OTHER, 32'hFFFF_FFFF);
    rdchk("sync kept", pts_pkg::IDX_SYNC_HI, 32'h0000_1234);
    rdchk("flags", pts_pkg::IDX_FLAGS, 32'h0000_6000);
    wr(pts_pkg::IDX_FLAGS, 32'h0000_FFFF);
    rdchk("flags", pts_pkg::IDX_FLAGS, 32'h0000_0000);
    // sync stamp lands on the access edge of its own clear
    fork
      wr(pts_pkg::IDX_FLAGS, 32'h0000_8000);
      begin
        repeat (2) @(posedge MCLK);
        stamp <= '{1'b1, pts_pkg::MSG_SYNC, 32'h0000_0077};
        @(posedge MCLK);
        stamp <= '{1'b0, pts_pkg::MSG_OTHER, 32'h0000_0000};
      end
    join
    rdchk("set wins", pts_pkg::IDX_FLAGS, 32'h0000_8000);
    rdchk("sync lo", pts_pkg::IDX_SYNC_LO, 32'h0000_0077);
    wr(pts_pkg::IDX_FLAGS, 32'h0000_8000);
    rdchk("flags", pts_pkg::IDX_FLAGS, 32'h0000_0000);
  endtask

  task automatic t_irq;
    wr(pts_pkg::IDX_IRQ_ON, 32'h0000_FFFF);
    rdchk("enables", pts_pkg::IDX_IRQ_ON, 32'h0000_E000);
    chk("irq enable", PTP_IRQ_ENABLE, 1'b1);
    chk("irq idle", IRQ, 1'b0);
    put_stamp(pts_pkg::MSG_SYNC, 32'h0000_0042);
    chk("irq status", PTP_IRQ_STATUS, 1'b1);
    chk("irq", IRQ, 1'b1);
    wr(pts_pkg::IDX_IRQ_ON, 32'h0000_2000);
    chk("irq masked", IRQ, 1'b0);
    put_stamp(pts_pkg::MSG_PREQ, 32'h0000_0043);
    chk("irq masked", IRQ, 1'b0);
    wr(pts_pkg::IDX_IRQ_ON, 32'h0000_4000);
    chk("irq req", IRQ, 1'b1);
    wr(pts_pkg::IDX_FLAGS, 32'h0000_4000);
    chk("irq status", PTP_IRQ_STATUS, 1'b1);
    chk("irq cleared", IRQ, 1'b0);
    wr(pts_pkg::IDX_FLAGS, 32'h0000_8000);
    chk("irq status", PTP_IRQ_STATUS, 1'b0);
    wr(pts_pkg::IDX_IRQ_ON, 32'h0000_0000);
    chk("irq enable", PTP_IRQ_ENABLE, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end

  initial
  begin
    RST         = 1'b1;
    PSEL        = 1'b0;
    PENABLE     = 1'b0;
    PWRITE      = 1'b0;
    PADDR       = 16'h0000;
    PWDATA      = 32'h0000_0000;
    PSTRB       = 4'h0;
    stamp       = '{1'b0, pts_pkg::MSG_OTHER, 32'h0000_0000};
    tx_msg      = '{1'b0, pts_pkg::MSG_OTHER, 64'h0000};
    send        = 1'b0;
    send_kind   = pts_pkg::MSG_OTHER;
    send_corr   = 64'h0000;
    fails       = 0;
    comparisons = 0;
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    t_reset;
    t_latency;
    t_corr;
    t_stamps;
    t_irq;
    wrap_up;
  end

  initial
  begin
    repeat (5000) @(posedge MCLK);
    fails++;
    wrap_up;
  end
endmodule
